// *** verilog/drive_protection_pkg.sv ***
package drive_protection_pkg;

   // ----------------------------------------------------------------
   // Clock and time base
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ           = 40_000_000;
   localparam int unsigned TICK_TIME_US     = 1000;
   localparam int unsigned TICK_CYCLES      = CLK_HZ / 1_000_000 * TICK_TIME_US;
   localparam int unsigned WAIT_UNIT_MS     = 100;
   localparam int unsigned BRAKE_CONT_S     = 15;
   localparam int unsigned BRAKE_CONT_MS    = BRAKE_CONT_S * 1000;
   localparam int unsigned DUTY_SCALE       = 100;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int unsigned SAMPLE_W         = 16;
   localparam int unsigned WAIT_W           = 11;
   localparam int unsigned LOSS_CNT_W       = 17;
   localparam int unsigned CONT_CNT_W       = 14;
   localparam int unsigned SEQ_CNT_W        = 24;
   localparam int unsigned IRQ_W            = 3;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CONFIG       = 8'h00;
   localparam logic [7:0] ADDR_LOSS_WAIT    = 8'h04;
   localparam logic [7:0] ADDR_BRAKE_DUTY   = 8'h08;
   localparam logic [7:0] ADDR_OUT_SELECT   = 8'h0C;
   localparam logic [7:0] ADDR_RATED_CURR   = 8'h10;
   localparam logic [7:0] ADDR_REF_MINIMUM  = 8'h14;
   localparam logic [7:0] ADDR_LIVE_STATUS  = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_MASK     = 8'h20;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned CFG_CRIT_LSB     = 0;
   localparam int unsigned CFG_ACTION_LSB   = 4;
   localparam int unsigned CFG_SRC_LSB      = 8;
   localparam int unsigned CFG_DUTY_LIM_BIT = 12;
   localparam int unsigned OSEL_TR_LSB      = 0;
   localparam int unsigned OSEL_RLY_LSB     = 8;
   localparam int unsigned RMIN_CURR_LSB    = 16;
   localparam int unsigned LIVE_OVERLOAD    = 0;
   localparam int unsigned LIVE_LOSS_SEEN   = 1;
   localparam int unsigned LIVE_LOSS_ACT    = 2;
   localparam int unsigned LIVE_BRAKE       = 3;
   localparam int unsigned LIVE_BRAKE_HOLD  = 4;
   localparam int unsigned IRQ_OVERLOAD     = 0;
   localparam int unsigned IRQ_LOSS         = 1;
   localparam int unsigned IRQ_BRAKE        = 2;

   // ----------------------------------------------------------------
   // Codes and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] CRIT_OFF          = 2'h0;
   localparam logic [1:0] CRIT_HALF         = 2'h1;
   localparam logic [1:0] CRIT_BELOW        = 2'h2;
   localparam logic [1:0] ACT_CONTINUE      = 2'h0;
   localparam logic [1:0] ACT_COAST         = 2'h1;
   localparam logic [1:0] ACT_DECEL         = 2'h2;
   localparam logic [2:0] SRC_VOLT          = 3'h3;
   localparam logic [2:0] SRC_CURR          = 3'h4;
   localparam logic [2:0] SRC_VOLT_CURR     = 3'h6;
   localparam logic [2:0] SRC_COMM          = 3'h7;
   localparam logic [4:0] OSEL_OVERLOAD     = 5'h06;
   localparam logic [4:0] OSEL_REF_LOSS     = 5'h0B;
   localparam logic [4:0] RST_TR_SEL        = 5'h0C;
   localparam logic [4:0] RST_RLY_SEL       = 5'h11;
   localparam logic [WAIT_W-1:0] RST_WAIT   = 11'h00A;
   localparam logic [WAIT_W-1:0] WAIT_MIN   = 11'h001;
   localparam logic [WAIT_W-1:0] WAIT_MAX   = 11'h4B0;
   localparam logic [4:0] RST_DUTY_PCT      = 5'h0A;
   localparam logic [4:0] DUTY_PCT_MAX      = 5'h1E;

   typedef enum logic [1:0] {LOSS_IDLE, LOSS_WAITING, LOSS_APPLIED}
      loss_state_e;

   typedef struct packed {
      logic [SAMPLE_W-1:0] volt;
      logic [SAMPLE_W-1:0] curr;
      logic                comm_valid;
   } ref_in_s;

   typedef struct packed {
      logic [1:0]        crit;
      logic [1:0]        action;
      logic [2:0]        src;
      logic              duty_lim;
      logic [WAIT_W-1:0] wait_time;
      logic [4:0]        duty_pct;
      logic [4:0]        tr_sel;
      logic [4:0]        rly_sel;
   } cfg_s;

endpackage

// *** verilog/tick_divider.sv ***
`timescale 1ns/1ps
module tick_divider
   import drive_protection_pkg::*;
#(
   parameter int unsigned CYCLES = TICK_CYCLES
)
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   output logic      tick
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (CYCLES < 2 || CYCLES > 32'h00FF_FFFF)
   begin : g_bad
      $error("tick_divider: CYCLES out of range");
   end

   typedef struct packed {
      logic [23:0] cnt;
      logic        tick;
   } tick_state_s;

   tick_state_s s;
   tick_state_s next_s;

   always_comb
   begin
      next_s      = s;
      next_s.tick = 1'b0;
      if (s.cnt == 24'(CYCLES - 1))
      begin
         next_s.cnt  = 24'h00_0000;
         next_s.tick = 1'b1;
      end
      else
      begin
         next_s.cnt = s.cnt + 24'h00_0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s <= '0;
      else if (ce)
         s <= next_s;
   end

   assign tick = s.tick;

endmodule

// *** verilog/drive_protection_monitor.sv ***
// Functional notes
// - Overload is flagged while measured current exceeds the rated current.
// - Output select code 6 drives that output during overload trip.
// - Output select code 11 drives that output on frequency command loss.
// - Loss is supervised on voltage, current or communication references.
// - Criterion 0 off, 1 below half minimum, 2 below minimum.
// - Combined source: loss if either input is below its minimum.
// - Loss action waits 0.1 to 120 s, default 1.0 s.
// - Action 0 holds frequency, 1 coasts, 2 decelerates to stop.
// - Duty limit select 1 restricts brake duty; 0 leaves it free.
// - Brake duty 0 to 30 percent, default 10, per sequence.
// - Brake enable never stays on longer than 15 s at once.
// - Duty is braking time over whole sequence time, in percent.
`timescale 1ns/1ps
module drive_protection_monitor
   import drive_protection_pkg::*;
#(
   parameter int unsigned          TICK_DIV   = TICK_CYCLES,
   parameter logic [SAMPLE_W-1:0]  RATED_RST  = 16'h0100,
   parameter logic [SAMPLE_W-1:0]  VMIN_RST   = 16'h0000,
   parameter logic [SAMPLE_W-1:0]  IMIN_RST   = 16'h0000
)
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                ce,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [SAMPLE_W-1:0] output_current,
   input  wire ref_in_s             ref_in,
   input  wire logic                brake_request,
   input  wire logic                seq_start,
   output logic                     open_collector_output,
   output logic                     alarm_relay,
   output logic                     output_shutoff,
   output logic                     decel_request,
   output logic                     hold_frequency,
   output logic                     brake_enable,
   output logic                     irq
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (RATED_RST == '0)
   begin : g_bad_rated
      $error("drive_protection_monitor: rated current must be nonzero");
   end

   typedef struct packed {
      cfg_s                  cfg;
      logic [SAMPLE_W-1:0]   rated;
      logic [SAMPLE_W-1:0]   vmin;
      logic [SAMPLE_W-1:0]   imin;
      loss_state_e           loss_st;
      logic [LOSS_CNT_W-1:0] loss_ms;
      logic [CONT_CNT_W-1:0] cont_ms;
      logic                  cont_hold;
      logic [SEQ_CNT_W-1:0]  seq_ms;
      logic [SEQ_CNT_W-1:0]  brake_ms;
      logic                  overload;
      logic                  brake_en;
      logic                  shutoff;
      logic                  decel;
      logic                  hold;
      logic                  oc_out;
      logic                  relay_out;
      logic [IRQ_W-1:0]      irq_status;
      logic [IRQ_W-1:0]      irq_mask;
      logic                  irq;
      logic [31:0]           prdata;
      logic                  pready;
      logic                  pslverr;
   } state_s;

   state_s s;
   state_s next_s;
   logic   tick;

   tick_divider #(
      .CYCLES (TICK_DIV)
   ) tick_divider_i (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .tick    (tick)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic below_min(input logic [SAMPLE_W-1:0] smp,
                                      input logic [SAMPLE_W-1:0] mn,
                                      input logic [1:0]          crit);
      logic r;
      r = 1'b0;
      case (crit)
         CRIT_HALF:  r = smp < (mn >> 1);
         CRIT_BELOW: r = smp < mn;
         default:    r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic out_drive(input logic [4:0] sel,
                                      input logic       ovl,
                                      input logic       lost);
      return ((sel == OSEL_OVERLOAD) && ovl)
          || ((sel == OSEL_REF_LOSS) && lost);
   endfunction

   function automatic logic addr_mapped(input logic [7:0] a);
      return a == ADDR_CONFIG || a == ADDR_LOSS_WAIT || a == ADDR_BRAKE_DUTY
          || a == ADDR_OUT_SELECT || a == ADDR_RATED_CURR
          || a == ADDR_REF_MINIMUM || a == ADDR_LIVE_STATUS
          || a == ADDR_IRQ_STATUS || a == ADDR_IRQ_MASK;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic                  setup;
      logic                  wr;
      logic                  loss_now;
      logic                  lost;
      logic                  duty_ok;
      logic [LOSS_CNT_W-1:0] wait_ms;
      logic [31:0]           used;
      logic [31:0]           allowed;
      logic [IRQ_W-1:0]      events;
      logic [IRQ_W-1:0]      clr;
      logic [31:0]           rd;
      next_s   = s;
      setup    = psel && !penable;
      wr       = psel && penable && s.pready && pwrite && !s.pslverr;
      events   = '0;
      clr      = '0;
      rd       = '0;
      loss_now = 1'b0;
      lost     = 1'b0;
      duty_ok  = 1'b0;
      wait_ms  = '0;
      used     = '0;
      allowed  = '0;

      // Register writes take effect at the completing access edge
      if (wr)
      begin
         case (paddr)
            ADDR_CONFIG:
            begin
               next_s.cfg.crit     = pwdata[CFG_CRIT_LSB +: 2];
               next_s.cfg.action   = pwdata[CFG_ACTION_LSB +: 2];
               next_s.cfg.src      = pwdata[CFG_SRC_LSB +: 3];
               next_s.cfg.duty_lim = pwdata[CFG_DUTY_LIM_BIT];
            end
            ADDR_LOSS_WAIT:
            begin
               if (pwdata[WAIT_W-1:0] > WAIT_MAX || pwdata[31:WAIT_W] != '0)
                  next_s.cfg.wait_time = WAIT_MAX;
               else if (pwdata[WAIT_W-1:0] < WAIT_MIN)
                  next_s.cfg.wait_time = WAIT_MIN;
               else
                  next_s.cfg.wait_time = pwdata[WAIT_W-1:0];
            end
            ADDR_BRAKE_DUTY:
            begin
               if (pwdata[31:0] > 32'(DUTY_PCT_MAX))
                  next_s.cfg.duty_pct = DUTY_PCT_MAX;
               else
                  next_s.cfg.duty_pct = pwdata[4:0];
            end
            ADDR_OUT_SELECT:
            begin
               next_s.cfg.tr_sel  = pwdata[OSEL_TR_LSB +: 5];
               next_s.cfg.rly_sel = pwdata[OSEL_RLY_LSB +: 5];
            end
            ADDR_RATED_CURR:  next_s.rated = pwdata[SAMPLE_W-1:0];
            ADDR_REF_MINIMUM:
            begin
               next_s.vmin = pwdata[SAMPLE_W-1:0];
               next_s.imin = pwdata[RMIN_CURR_LSB +: SAMPLE_W];
            end
            ADDR_IRQ_STATUS:  clr = pwdata[IRQ_W-1:0];
            ADDR_IRQ_MASK:    next_s.irq_mask = pwdata[IRQ_W-1:0];
            default:          next_s.irq_mask = s.irq_mask;
         endcase
      end

      next_s.overload = output_current > s.rated;

      case (s.cfg.src)
         SRC_VOLT:      loss_now = below_min(ref_in.volt, s.vmin, s.cfg.crit);
         SRC_CURR:      loss_now = below_min(ref_in.curr, s.imin, s.cfg.crit);
         SRC_VOLT_CURR: loss_now = below_min(ref_in.volt, s.vmin, s.cfg.crit)
                                 || below_min(ref_in.curr, s.imin, s.cfg.crit);
         // criterion 0 also disables comm check
         SRC_COMM:      loss_now = (s.cfg.crit != CRIT_OFF)
                                 && !ref_in.comm_valid;
         default:       loss_now = 1'b0;
      endcase

      wait_ms  = LOSS_CNT_W'(s.cfg.wait_time * WAIT_UNIT_MS);
      case (s.loss_st)
         LOSS_IDLE:
         begin
            next_s.loss_ms = '0;
            if (loss_now)
               next_s.loss_st = LOSS_WAITING;
         end
         LOSS_WAITING:
         begin
            if (!loss_now)
               next_s.loss_st = LOSS_IDLE;
            else if (tick)
            begin
               next_s.loss_ms = s.loss_ms + 1'b1;
               if (next_s.loss_ms > wait_ms)
               begin
                  next_s.loss_st   = LOSS_APPLIED;
                  events[IRQ_LOSS] = 1'b1;
               end
            end
         end
         LOSS_APPLIED:
         begin
            if (!loss_now)
               next_s.loss_st = LOSS_IDLE;
         end
         default: next_s.loss_st = LOSS_IDLE;
      endcase
      lost = next_s.loss_st == LOSS_APPLIED;

      next_s.hold    = lost && s.cfg.action == ACT_CONTINUE;
      next_s.decel   = lost && s.cfg.action == ACT_DECEL;
      next_s.shutoff = next_s.overload || (lost && s.cfg.action == ACT_COAST);

      next_s.oc_out    = out_drive(s.cfg.tr_sel, next_s.overload, lost);
      next_s.relay_out = out_drive(s.cfg.rly_sel, next_s.overload, lost);

      // Sequence time base; counters saturate instead of wrapping so a
      // very long sequence cannot suddenly grant braking again
      if (seq_start)
      begin
         next_s.seq_ms   = '0;
         next_s.brake_ms = '0;
      end
      else if (tick)
      begin
         if (s.seq_ms != '1)
            next_s.seq_ms = s.seq_ms + 1'b1;
         if (s.brake_en && s.brake_ms != '1)
            next_s.brake_ms = s.brake_ms + 1'b1;
      end

      // braking time versus whole sequence time
      used    = 32'(s.brake_ms) * 32'(DUTY_SCALE);
      allowed = 32'(s.seq_ms) * 32'(s.cfg.duty_pct);
      duty_ok = !s.cfg.duty_lim || (used < allowed);

      if (!brake_request)
      begin
         next_s.cont_ms   = '0;
         next_s.cont_hold = 1'b0;
      end
      else if (tick && s.brake_en)
      begin
         next_s.cont_ms = s.cont_ms + 1'b1;
         if (next_s.cont_ms >= CONT_CNT_W'(BRAKE_CONT_MS))
            next_s.cont_hold = 1'b1;
      end
      next_s.brake_en = brake_request && duty_ok && !next_s.cont_hold;

      events[IRQ_OVERLOAD] = next_s.overload && !s.overload;
      events[IRQ_BRAKE]    = s.brake_en && brake_request && !next_s.brake_en;

      // Set wins over a same-cycle clear
      next_s.irq_status = (s.irq_status & ~clr) | events;
      next_s.irq        = |(next_s.irq_status & next_s.irq_mask);

      // Read data is captured in setup so prdata comes from a flop
      case (paddr)
         ADDR_CONFIG:
         begin
            rd[CFG_CRIT_LSB +: 2]   = s.cfg.crit;
            rd[CFG_ACTION_LSB +: 2] = s.cfg.action;
            rd[CFG_SRC_LSB +: 3]    = s.cfg.src;
            rd[CFG_DUTY_LIM_BIT]    = s.cfg.duty_lim;
         end
         ADDR_LOSS_WAIT:   rd[WAIT_W-1:0] = s.cfg.wait_time;
         ADDR_BRAKE_DUTY:  rd[4:0] = s.cfg.duty_pct;
         ADDR_OUT_SELECT:
         begin
            rd[OSEL_TR_LSB +: 5]  = s.cfg.tr_sel;
            rd[OSEL_RLY_LSB +: 5] = s.cfg.rly_sel;
         end
         ADDR_RATED_CURR:  rd[SAMPLE_W-1:0] = s.rated;
         ADDR_REF_MINIMUM:
         begin
            rd[SAMPLE_W-1:0]              = s.vmin;
            rd[RMIN_CURR_LSB +: SAMPLE_W] = s.imin;
         end
         ADDR_LIVE_STATUS:
         begin
            rd[LIVE_OVERLOAD]   = s.overload;
            rd[LIVE_LOSS_SEEN]  = s.loss_st != LOSS_IDLE;
            rd[LIVE_LOSS_ACT]   = s.loss_st == LOSS_APPLIED;
            rd[LIVE_BRAKE]      = s.brake_en;
            rd[LIVE_BRAKE_HOLD] = s.cont_hold;
         end
         ADDR_IRQ_STATUS:  rd[IRQ_W-1:0] = s.irq_status;
         ADDR_IRQ_MASK:    rd[IRQ_W-1:0] = s.irq_mask;
         default:          rd = '0;
      endcase
      next_s.pready  = setup;
      next_s.pslverr = setup && !addr_mapped(paddr);
      if (setup)
         next_s.prdata = rd;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s              <= '0;
         s.cfg.wait_time <= RST_WAIT;
         s.cfg.duty_pct <= RST_DUTY_PCT;
         s.cfg.duty_lim <= 1'b1;
         s.cfg.tr_sel   <= RST_TR_SEL;
         s.cfg.rly_sel  <= RST_RLY_SEL;
         s.rated        <= RATED_RST;
         s.vmin         <= VMIN_RST;
         s.imin         <= IMIN_RST;
         s.loss_st      <= LOSS_IDLE;
      end
      else if (ce)
      begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata                = s.prdata;
   assign pready                = s.pready;
   assign pslverr               = s.pslverr;
   assign open_collector_output = s.oc_out;
   assign alarm_relay           = s.relay_out;
   assign output_shutoff        = s.shutoff;
   assign decel_request         = s.decel;
   assign hold_frequency        = s.hold;
   assign brake_enable          = s.brake_en;
   assign irq                   = s.irq;

endmodule

// *** test/drive_protection_props.sv ***
`timescale 1ns/1ps
module drive_protection_props
   import drive_protection_pkg::*;
#(
   parameter int unsigned         TICK_DIV  = TICK_CYCLES,
   parameter logic [SAMPLE_W-1:0] RATED_RST = 16'h0100
)
(
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                ce,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire logic [SAMPLE_W-1:0] output_current,
   input wire logic                brake_request,
   input wire logic                output_shutoff,
   input wire logic                decel_request,
   input wire logic                hold_frequency,
   input wire logic                brake_enable
);
   // Two ticks of slack: the hold counts whole ticks, not cycles
   localparam int ON_MAX = BRAKE_CONT_MS * TICK_DIV + 2 * TICK_DIV;
   int on_cnt;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         on_cnt <= 0;
      else
         on_cnt <= brake_enable ? on_cnt + 1 : 0;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_setup_answer:
      assert property (psel && !penable && ce |=> pready)
      else $error("no ready after setup");
   a_ready_cause:
      assert property (pready |-> $past(psel && !penable))
      else $error("ready without setup");
   a_ready_single:
      assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_quiet:
      assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("error response malformed");
   a_overload_cut:
      assert property (ce && output_current > RATED_RST |=> output_shutoff)
      else $error("overload did not cut output");
   a_action_single:
      assert property ($onehot0({decel_request, hold_frequency}))
      else $error("two loss actions at once");
   a_brake_cause:
      assert property (brake_enable |-> $past(brake_request))
      else $error("brake enabled without request");
   a_brake_limit:
      assert property (on_cnt <= ON_MAX)
      else $error("brake enable held too long");
endmodule
bind drive_protection_monitor drive_protection_props #(
   .TICK_DIV(TICK_DIV), .RATED_RST(RATED_RST)) drive_protection_props_i (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .output_current(output_current),
   .brake_request(brake_request), .output_shutoff(output_shutoff),
   .decel_request(decel_request), .hold_frequency(hold_frequency),
   .brake_enable(brake_enable));

// *** test/drive_plant_model.sv ***
`timescale 1ns/1ps
module drive_plant_model
   import drive_protection_pkg::*;
(
   input  wire logic [SAMPLE_W-1:0] load_current,
   input  wire ref_in_s             ref_set,
   input  wire logic                brake_demand,
   input  wire logic                decel_request,
   output logic      [SAMPLE_W-1:0] output_current,
   output ref_in_s                  ref_in,
   output logic                     brake_request
);
   assign output_current = load_current;
   assign ref_in = ref_set;
   // Ramping down returns energy, so the chopper asks for the resistor
   assign brake_request = brake_demand | decel_request;
endmodule

// *** test/drive_protection_monitor_bench.sv ***
`timescale 1ns/1ps
module drive_protection_monitor_bench
   import drive_protection_pkg::*;
;
   localparam int TD = 4;
   localparam logic [32:0] GOOD = {16'h0200, 16'h0200, 1'b1};
   logic [32:0] bad_t [6] = '{{16'h0090, 16'h0200, 1'b1},
      {16'h007F, 16'h0200, 1'b1}, {16'h0200, 16'h00FF, 1'b1},
      {16'h0200, 16'h00FF, 1'b1}, GOOD ^ 33'h0_0000_0001,
      {16'h0000, 16'h0200, 1'b1}};
   logic [31:0] cfg_t [6] = '{32'h0000_1301, 32'h0000_1301,
      32'h0000_1412, 32'h0000_1622, 32'h0000_1701, 32'h0000_1310};
   logic [3:0]  exp_t [6] = '{4'h0, 4'h9, 4'hC, 4'hA, 4'h9, 4'h0};
   logic pclk, presetn, psel, penable, pwrite, brake_demand, seq_start, ce;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, brake_request;
   logic [SAMPLE_W-1:0] load_current, output_current;
   ref_in_s ref_set, ref_in;
   wire [6:0] outs;
   int bad_count, cmp_count, n;
   drive_protection_monitor #(.TICK_DIV(TD)) drive_protection_monitor_i (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .output_current(output_current), .ref_in(ref_in),
      .brake_request(brake_request), .seq_start(seq_start),
      .open_collector_output(outs[6]), .alarm_relay(outs[5]),
      .output_shutoff(outs[4]), .decel_request(outs[3]),
      .hold_frequency(outs[2]), .brake_enable(outs[1]), .irq(outs[0]));
   drive_plant_model drive_plant_model_i (
      .load_current(load_current), .ref_set(ref_set),
      .brake_demand(brake_demand), .decel_request(outs[3]),
      .output_current(output_current), .ref_in(ref_in),
      .brake_request(brake_request));
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_out(input int b, input logic v, input int lim);
      n = 0;
      while (outs[b] !== v)
      begin
         @(posedge pclk);
         n++;
         if (n > lim)
         begin
            bad_count++;
            complete_run;
         end
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         bad_count++;
         complete_run;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, e);
   endtask
   initial
   begin
      {ce, psel, penable, pwrite, brake_demand, seq_start} = 6'h20;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      load_current = 16'h0000;
      ref_set = GOOD;
      presetn = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(ADDR_CONFIG, 32'h0000_1000);
      rd_chk(ADDR_LOSS_WAIT, 32'h0000_000A);
      rd_chk(ADDR_BRAKE_DUTY, 32'h0000_000A);
      rd_chk(ADDR_OUT_SELECT, 32'h0000_110C);
      rd_chk(ADDR_RATED_CURR, 32'h0000_0100);
      rd_chk(8'h24, 32'h0000_0000);
      check(32'(err), 32'h0000_0001);
      apb(1'b1, ADDR_LOSS_WAIT, 32'h0000_1000);
      rd_chk(ADDR_LOSS_WAIT, 32'h0000_04B0);
      apb(1'b1, ADDR_LOSS_WAIT, 32'h0000_0000);
      rd_chk(ADDR_LOSS_WAIT, 32'h0000_0001);
      apb(1'b1, ADDR_BRAKE_DUTY, 32'h0000_001F);
      rd_chk(ADDR_BRAKE_DUTY, 32'h0000_001E);
      $display("registers done");
      apb(1'b1, ADDR_OUT_SELECT, 32'h0000_0B06);
      apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0007);
      load_current <= 16'h0101;
      repeat (3) @(posedge pclk);
      check(32'(outs), 32'h0000_0051);
      load_current <= 16'h0100;
      repeat (3) @(posedge pclk);
      check(32'(outs), 32'h0000_0001);
      rd_chk(ADDR_IRQ_STATUS, 32'h0000_0001);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0001);
      repeat (3) @(posedge pclk);
      check(32'(outs[0]), 32'h0000_0000);
      ce <= 1'b0;
      load_current <= 16'h0101;
      repeat (3) @(posedge pclk);
      check(32'(outs[4]), 32'h0000_0000);
      ce <= 1'b1;
      load_current <= 16'h0100;
      $display("overload done");
      apb(1'b1, ADDR_REF_MINIMUM, 32'h0100_0100);
      for (int k = 0; k < 6; k++)
      begin
         apb(1'b1, ADDR_CONFIG, cfg_t[k]);
         ref_set <= bad_t[k];
         repeat (300) @(posedge pclk);
         check(32'(outs[5:2]), 32'h0000_0000);
         repeat (220) @(posedge pclk);
         check(32'(outs[5]), 32'(exp_t[k][3]));
         check(32'(outs[4:2]), 32'(exp_t[k][2:0]));
         ref_set <= GOOD;
         repeat (3) @(posedge pclk);
         check(32'(outs[5:2]), 32'h0000_0000);
      end
      apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0007);
      $display("loss done");
      apb(1'b1, ADDR_CONFIG, 32'h0000_0000);
      brake_demand <= 1'b1;
      wait_out(1, 1'b1, 8);
      wait_out(1, 1'b0, 61000);
      check(32'(n > 59990 && n < 60010), 32'h0000_0001);
      rd_chk(ADDR_IRQ_STATUS, 32'h0000_0004);
      rd_chk(ADDR_LIVE_STATUS, 32'h0000_0010);
      check(32'(outs[1:0]), 32'h0000_0001);
      brake_demand <= 1'b0;
      apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0004);
      $display("brake hold done");
      apb(1'b1, ADDR_CONFIG, 32'h0000_1000);
      apb(1'b1, ADDR_BRAKE_DUTY, 32'h0000_000A);
      seq_start <= 1'b1;
      @(posedge pclk);
      seq_start <= 1'b0;
      brake_demand <= 1'b1;
      n = 0;
      repeat (4000)
      begin
         @(posedge pclk);
         n += int'(outs[1] === 1'b1);
      end
      check(32'(n > 360 && n < 440), 32'h0000_0001);
      brake_demand <= 1'b0;
      $display("brake duty done");
      complete_run;
   end
endmodule
